// ===== inc/ppc_regs.svh
// register offsets, reset values, writable and restore masks, open-drain pin indices
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

`define PPC_PIN_CTRL_ADDR       8'h18
`define PPC_PATH_CTRL_ADDR      8'h19

`define PPC_PIN_CTRL_RESET      8'hc0
`define PPC_PATH_CTRL_RESET     8'h20

// writable bits of the power-path register; the rest read zero
`define PPC_PATH_CTRL_RW_MASK   8'he1

// fields restored by watchdog expiry
`define PPC_PIN_CTRL_WD_MASK    8'hc0
`define PPC_PATH_CTRL_WD_MASK   8'h41
// fields cleared by adapter plug-in
`define PPC_PATH_CTRL_PLUG_MASK 8'h01

// open-drain pin index
`define PPC_OD_STATUS_OUT_ONE            0
`define PPC_OD_STATUS_OUT_TWO            1
`define PPC_OD_STAT3            2
`define PPC_OD_STAT4            3
`define PPC_OD_PINS             4

`define PPC_READ_NONE           8'h00

`endif

// ===== inc/ppc_pkg.sv
// field layouts of the pin and power-path control registers
package ppc_pkg;

  typedef struct packed {
    logic current_set_pin_enable;
    logic input_limit_pin_enable;
    logic power_good_pin_disable;
    logic status_pins_disable;
    logic force_status_four_low;
    logic force_status_three_low;
    logic force_status_two_low;
    logic force_status_one_low;
  } ppc_pin_ctrl_s;

  typedef struct packed {
    logic       register_reset;
    logic       input_load_sink_enable;
    logic       pulse_skip_enable;
    logic [3:0] reserved;
    logic       reverse_mode_enable;
  } ppc_path_ctrl_s;

endpackage

// ===== design/ppc_top.sv
// pin function and power-path control register pair with pin overrides
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.svh"

module ppc_top (
  input  wire logic       clk,
  input  wire logic       srst,
  // register port from the serial interface engine
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output var  logic [7:0] reg_rdata,
  // system events
  input  wire logic       watchdog_expire,
  input  wire logic       adapter_plug_in,
  input  wire logic       sync_valid,
  input  wire logic       charge_enable_pin_disable,
  // normal pull-low requests of status_out_one, status_out_two, power-good
  input  wire logic [2:0] status_normal_low,
  // control levels to the charger core
  output logic            current_set_pin_enable,
  output logic            input_limit_pin_enable,
  output logic            power_good_pin_disable,
  output logic            status_pins_disable,
  output logic            input_load_sink_enable,
  output logic            pulse_skip_enable,
  output logic            reverse_mode_enable,
  output logic            register_reset_pulse,
  // open-drain pins: status_out_one, status_out_two, power-good/stat3, charge-enable/stat4
  output var  logic [3:0] od_out,
  output var  logic [3:0] od_oe
);

  ppc_pkg::ppc_pin_ctrl_s  pin_ctrl;
  ppc_pkg::ppc_path_ctrl_s path_ctrl;
  logic                    sync_valid_q;

  // address match, shared by read and write decode
  function automatic logic ppc_addr_hit(
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return addr == target;
  endfunction

  // replace masked bits with their reset values
  function automatic logic [7:0] ppc_restore(
    input logic [7:0] value,
    input logic [7:0] rst_val,
    input logic [7:0] mask
  );
    return (value & ~mask) | (rst_val & mask);
  endfunction

  // address decode
  wire logic pin_hit  = ppc_addr_hit(reg_addr, `PPC_PIN_CTRL_ADDR);
  wire logic path_hit = ppc_addr_hit(reg_addr, `PPC_PATH_CTRL_ADDR);
  wire logic pin_wr   = reg_wr & pin_hit;
  wire logic path_wr  = reg_wr & path_hit;

  // a pending register reset is the stored reset bit itself
  wire logic reg_reset_now = path_ctrl.register_reset;

  // rising edge of the sync detector output
  wire logic sync_rise = sync_valid & ~sync_valid_q;

  // pin register next value: write, then watchdog, then register reset
  wire logic [7:0] pin_after_wr = pin_wr ? reg_wdata : pin_ctrl;
  wire logic [7:0] pin_after_wd = watchdog_expire ?
    ppc_restore(pin_after_wr, `PPC_PIN_CTRL_RESET,
                `PPC_PIN_CTRL_WD_MASK) : pin_after_wr;
  wire logic [7:0] next_pin_ctrl = reg_reset_now ?
    `PPC_PIN_CTRL_RESET : pin_after_wd;

  // power-path next value; a host write in the sync cycle keeps priority
  wire logic [7:0] path_after_wr = path_wr ?
    (reg_wdata & `PPC_PATH_CTRL_RW_MASK) : path_ctrl;
  wire logic [7:0] path_after_sync = (sync_rise & ~path_wr) ?
    (path_after_wr & ~8'h20) : path_after_wr;
  wire logic [7:0] path_after_wd = watchdog_expire ?
    ppc_restore(path_after_sync, `PPC_PATH_CTRL_RESET,
                `PPC_PATH_CTRL_WD_MASK) : path_after_sync;
  wire logic [7:0] path_after_plug = adapter_plug_in ?
    ppc_restore(path_after_wd, `PPC_PATH_CTRL_RESET,
                `PPC_PATH_CTRL_PLUG_MASK) : path_after_wd;
  wire logic [7:0] next_path_ctrl = reg_reset_now ?
    `PPC_PATH_CTRL_RESET : path_after_plug;

  // read selection; unmapped offsets read zero
  wire logic [7:0] next_rdata = pin_hit  ? pin_ctrl  :
                                path_hit ? path_ctrl :
                                `PPC_READ_NONE;

  // per-pin function-off and force terms
  wire logic [3:0] function_off = {charge_enable_pin_disable,
                                   pin_ctrl.power_good_pin_disable,
                                   pin_ctrl.status_pins_disable,
                                   pin_ctrl.status_pins_disable};
  wire logic [3:0] force_low = {pin_ctrl.force_status_four_low,
                                pin_ctrl.force_status_three_low,
                                pin_ctrl.force_status_two_low,
                                pin_ctrl.force_status_one_low};
  // charge-enable pin is an input while its function is on
  wire logic [3:0] normal_low = {1'b0, status_normal_low};
  logic      [3:0] next_od_oe;

  // override applies only while the pin function is off
  genvar gi;
  generate
    for (gi = 0; gi < `PPC_OD_PINS; gi++)
    begin : g_od
      assign next_od_oe[gi] = function_off[gi] ?
        force_low[gi] : normal_low[gi];
    end
  endgenerate

  // control registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pin_ctrl  <= `PPC_PIN_CTRL_RESET;
      path_ctrl <= `PPC_PATH_CTRL_RESET;
    end
    else
    begin
      pin_ctrl  <= next_pin_ctrl;
      path_ctrl <= next_path_ctrl;
    end
  end

  // read data, sync edge history and pin drivers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reg_rdata    <= `PPC_READ_NONE;
      sync_valid_q <= 1'b0;
      od_oe        <= 4'h0;
      od_out       <= 4'h0;
    end
    else
    begin
      reg_rdata    <= next_rdata;
      sync_valid_q <= sync_valid;
      od_oe        <= next_od_oe;
      od_out       <= 4'h0; // open drain only ever pulls low
    end
  end

  // control levels come straight from the register flops
  assign current_set_pin_enable = pin_ctrl.current_set_pin_enable;
  assign input_limit_pin_enable = pin_ctrl.input_limit_pin_enable;
  assign power_good_pin_disable = pin_ctrl.power_good_pin_disable;
  assign status_pins_disable    = pin_ctrl.status_pins_disable;
  assign input_load_sink_enable = path_ctrl.input_load_sink_enable;
  assign pulse_skip_enable      = path_ctrl.pulse_skip_enable;
  assign reverse_mode_enable    = path_ctrl.reverse_mode_enable;
  // tells the other register banks to reset with us
  assign register_reset_pulse   = path_ctrl.register_reset;

endmodule
`default_nettype wire

// ===== test/ppc_properties.sv
// port-level checks of the pin and power-path control registers
`timescale 1ns/1ps
`default_nettype none
module ppc_properties (
  input wire logic       clk, srst, reg_wr, watchdog_expire, adapter_plug_in,
  input wire logic       sync_valid, charge_enable_pin_disable,
  input wire logic       register_reset_pulse, current_set_pin_enable,
  input wire logic       input_limit_pin_enable, power_good_pin_disable,
  input wire logic       status_pins_disable, input_load_sink_enable,
  input wire logic       pulse_skip_enable, reverse_mode_enable,
  input wire logic [2:0] status_normal_low,
  input wire logic [3:0] od_out, od_oe,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // register writes, restores and readback
  a_pin_write: assert property (reg_wr && reg_addr == 8'h18 && !watchdog_expire
    && !register_reset_pulse
    |=> {current_set_pin_enable, input_limit_pin_enable, power_good_pin_disable,
    status_pins_disable} == $past(reg_wdata[7:4])) else $error("pin write");
  a_path_write: assert property (reg_wr && reg_addr == 8'h19 && !reg_wdata[7]
    && !watchdog_expire && !adapter_plug_in && sync_valid == $past(sync_valid, 2)
    && !register_reset_pulse
    |=> {input_load_sink_enable, pulse_skip_enable, reverse_mode_enable} ==
    {$past(reg_wdata[6:5]), $past(reg_wdata[0])}) else $error("path write");
  a_reg_reset: assert property (reg_wr && reg_addr == 8'h19 && reg_wdata[7]
    |=> register_reset_pulse ##1 !register_reset_pulse && current_set_pin_enable
    && input_limit_pin_enable && pulse_skip_enable && !reverse_mode_enable)
    else $error("register reset");
  a_watchdog_restore: assert property (watchdog_expire && !reg_wr
    && !adapter_plug_in && !register_reset_pulse
    |=> current_set_pin_enable && input_limit_pin_enable
    && !input_load_sink_enable && !reverse_mode_enable
    && $stable(power_good_pin_disable)) else $error("watchdog restore");
  a_plug_clear: assert property (adapter_plug_in |=> !reverse_mode_enable)
    else $error("plug-in clear");
  a_sync_clear: assert property ($rose(sync_valid) && !reg_wr
    && !register_reset_pulse ##1 !reg_wr && !register_reset_pulse
    ##1 !reg_wr |-> !pulse_skip_enable) else $error("sync clear");
  a_path_readback: assert property (reg_addr == 8'h19 |=> reg_rdata[6:0] ==
    {$past(input_load_sink_enable), $past(pulse_skip_enable), 4'h0,
    $past(reverse_mode_enable)}) else $error("path readback");
  // open-drain pins follow normal requests while their function is on
  a_status_pins: assert property (!status_pins_disable |=> od_oe[1:0] ==
    $past(status_normal_low[1:0]) && od_out == 4'h0) else $error("status pins");
  a_good_pin: assert property (!power_good_pin_disable |=> od_oe[2] ==
    $past(status_normal_low[2])) else $error("power-good pin");
  a_four_gate: assert property (!charge_enable_pin_disable |=> !od_oe[3])
    else $error("status-four gate");
endmodule
bind ppc_top ppc_properties u_props (.*);
`default_nettype wire

// ===== test/ppc_host_model.sv
// host model that writes and reads the control registers
`timescale 1ns/1ps
`default_nettype none
module ppc_host_model #(parameter int term_ma = 3000) (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output var  logic [7:0] reg_addr, reg_wdata,
  output var  logic       reg_wr
);
  initial {reg_addr, reg_wdata, reg_wr} = 17'h0;
  // one-cycle strobe; low termination current keeps pulse-skip off
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= (a == 8'h19 && term_ma < 2000) ? d & 8'hdf : d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // address held, data taken one edge after it is sampled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1 d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the pin and power-path control registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, srst = 1, watchdog_expire = 0, adapter_plug_in = 0;
  logic sync_valid = 0, charge_enable_pin_disable = 0;
  logic [2:0] status_normal_low = 3'h0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, pin, path;
  logic [3:0] od_out, od_oe;
  logic reg_wr, current_set_pin_enable, input_limit_pin_enable;
  logic power_good_pin_disable, status_pins_disable, input_load_sink_enable;
  logic pulse_skip_enable, reverse_mode_enable, register_reset_pulse;
  int miscompares = 0, comparisons = 0;
  logic [31:0] seed = 32'd96149;
  ppc_top u_dut (.*);
  ppc_host_model u_host (.*);
  always #12.5 clk = ~clk;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // readback and port levels against the bench model
  task automatic cmp_all();
    u_host.rd(8'h18, d);
    chk("pin reg", d, pin);
    u_host.rd(8'h19, d);
    chk("path reg", d, path);
    chk("levels", {current_set_pin_enable, input_limit_pin_enable,
      power_good_pin_disable, status_pins_disable, input_load_sink_enable,
      pulse_skip_enable, reverse_mode_enable, register_reset_pulse},
      {pin[7:4], path[6:5], path[0], 1'b0});
    chk("od pins", {od_out, od_oe}, {4'h0, charge_enable_pin_disable & pin[3],
      pin[5] ? pin[2] : status_normal_low[2],
      pin[4] ? pin[1:0] : status_normal_low[1:0]});
  endtask
  initial
  begin
    repeat (50000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  // random writes mixed with watchdog, plug-in and register reset, then a sync edge
  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    {pin, path} = 16'hc020;
    cmp_all();
    u_host.rd(8'h3c, d);
    chk("unmapped", d, 8'h00);
    for (int i = 0; i < 24; i++)
    begin
      status_normal_low <= 3'(rnd());
      charge_enable_pin_disable <= rnd() > 8'h7f;
      pin = rnd();
      u_host.wr(8'h18, pin);
      path = rnd() & 8'h7f;
      u_host.wr(8'h19, path);
      path &= 8'h61;
      @(posedge clk);
      watchdog_expire <= i % 4 == 1;
      adapter_plug_in <= i % 4 == 2;
      @(posedge clk);
      {watchdog_expire, adapter_plug_in} <= 2'b00;
      if (i % 4 == 1) {pin[7:6], path[6], path[0]} = 4'hc;
      if (i % 4 == 2) path[0] = 1'b0;
      if (i % 4 == 3)
      begin
        u_host.wr(8'h19, 8'h80 | rnd());
        #1 chk("reset pulse", {7'h0, register_reset_pulse}, 8'h01);
        {pin, path} = 16'hc020;
      end
      cmp_all();
    end
    @(posedge clk);
    sync_valid <= 1'b1;
    path[5] = 1'b0;
    cmp_all();
    u_host.wr(8'h19, 8'h20);
    path = 8'h20;
    cmp_all();
    end_sim();
  end
endmodule
`default_nettype wire
